// ==== pkg/uem_pkg.sv ====
// Shared constants and carriers for the endpoint mode and counter block.
// Assumes one 100 MHz clock shared by the APB side and the serial interface engine.
`default_nettype none
package uem_pkg;
	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_CNT0 = 8'h11;
	localparam logic [7:0] IDX_MODE0 = 8'h12;
	localparam logic [7:0] IDX_CNT1 = 8'h13;
	localparam logic [7:0] IDX_MODE1 = 8'h14;
	localparam logic [7:0] IDX_CNT2 = 8'h15;
	localparam logic [7:0] IDX_MODE2 = 8'h16;
	localparam logic [7:0] IDX_CNT3 = 8'h41;
	localparam logic [7:0] IDX_MODE3 = 8'h42;
	localparam logic [7:0] IDX_CNT4 = 8'h43;
	localparam logic [7:0] IDX_MODE4 = 8'h44;
	localparam logic [7:0] IDX_IRQ = 8'h20;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ==========================================================
	// Field positions
	localparam int MODE_STALL_BIT = 7;
	localparam int MODE_SETUP_BIT = 7;
	localparam int MODE_IN_BIT = 6;
	localparam int MODE_OUT_BIT = 5;
	localparam int MODE_ACK_BIT = 4;
	localparam int CNT_TOG_BIT = 7;
	localparam int CNT_DVAL_BIT = 6;
	localparam logic [5:0] CRC_BYTES = 6'h02;
	// ==========================================================
	// Mode codes
	localparam logic [3:0] M_DISABLE = 4'h0;
	localparam logic [3:0] M_NAK_INOUT = 4'h1;
	localparam logic [3:0] M_STATUS_OUT = 4'h2;
	localparam logic [3:0] M_STALL_INOUT = 4'h3;
	localparam logic [3:0] M_IGNORE_INOUT = 4'h4;
	localparam logic [3:0] M_ISO_OUT = 4'h5;
	localparam logic [3:0] M_STATUS_IN = 4'h6;
	localparam logic [3:0] M_ISO_IN = 4'h7;
	localparam logic [3:0] M_NAK_OUT = 4'h8;
	localparam logic [3:0] M_ACK_OUT = 4'h9;
	localparam logic [3:0] M_NAK_OUT_STIN = 4'ha;
	localparam logic [3:0] M_ACK_OUT_STIN = 4'hb;
	localparam logic [3:0] M_NAK_IN = 4'hc;
	localparam logic [3:0] M_ACK_IN = 4'hd;
	localparam logic [3:0] M_NAK_IN_STOUT = 4'he;
	localparam logic [3:0] M_ACK_IN_STOUT = 4'hf;
	// ==========================================================
	// Token kinds and answers
	localparam logic [1:0] PID_SETUP = 2'h1;
	localparam logic [1:0] PID_IN = 2'h2;
	localparam logic [1:0] PID_OUT = 2'h3;
	localparam logic [2:0] RSP_IGNORE = 3'h0;
	localparam logic [2:0] RSP_ACK = 3'h1;
	localparam logic [2:0] RSP_NAK = 3'h2;
	localparam logic [2:0] RSP_STALL = 3'h3;
	localparam logic [2:0] RSP_TXCNT = 3'h4;
	localparam logic [2:0] RSP_TX0 = 3'h5;
	localparam logic [2:0] RSP_RXISO = 3'h6;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic valid;
		logic [2:0] ep;
		logic [1:0] pid;
		logic crc_ok;
		logic zero_len;
		logic tog;
	} uem_tok_s;
	typedef struct packed {
		logic valid;
		logic hs_ack;
		logic [5:0] rx_bytes;
	} uem_upd_s;
	typedef struct packed {
		logic valid;
		logic [2:0] code;
		logic [5:0] count;
		logic tog;
	} uem_rsp_s;
	typedef struct packed {
		logic hit;
		logic is_mode;
		logic is_irq;
		logic [2:0] ep;
	} uem_dec_s;
endpackage
`default_nettype wire

// ==== hw/uem_endpoint_regs.sv ====
// Endpoint mode and counter registers with token answer decode.
// Assumes an APB master and a serial interface engine on clk_sys; engine strobes are synchronous.
`default_nettype none
module uem_endpoint_regs
	import uem_pkg::*;
#(
	parameter int NUM_EP = 5
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire uem_tok_s tok,
	input wire uem_upd_s upd,
	input wire logic setup_point,
	input wire logic ctrl_write_end,
	output uem_rsp_s rsp,
	output logic [NUM_EP-1:0] ep_irq,
	output logic ep0_setup_flag
);
	// Register map is fixed at five endpoints
	if (NUM_EP != 5) begin : g_ep_check
		$error("NUM_EP must be 5: register map is fixed");
	end

	// ==========================================================
	// Functions
	function automatic uem_dec_s decode(input logic [7:0] idx);
		uem_dec_s d;
		d = '{hit: 1'b1, is_mode: 1'b0, is_irq: 1'b0, ep: 3'h0};
		unique case (idx)
			IDX_CNT0: d.ep = 3'h0;
			IDX_CNT1: d.ep = 3'h1;
			IDX_CNT2: d.ep = 3'h2;
			IDX_CNT3: d.ep = 3'h3;
			IDX_CNT4: d.ep = 3'h4;
			IDX_MODE0: begin
				d.ep = 3'h0;
				d.is_mode = 1'b1;
			end
			IDX_MODE1: begin
				d.ep = 3'h1;
				d.is_mode = 1'b1;
			end
			IDX_MODE2: begin
				d.ep = 3'h2;
				d.is_mode = 1'b1;
			end
			IDX_MODE3: begin
				d.ep = 3'h3;
				d.is_mode = 1'b1;
			end
			IDX_MODE4: begin
				d.ep = 3'h4;
				d.is_mode = 1'b1;
			end
			IDX_IRQ: d.is_irq = 1'b1;
			default: d.hit = 1'b0;
		endcase
		return d;
	endfunction

	// Answer for a token; crc is taken as good here
	function automatic logic [2:0] answer(input logic [3:0] mode, input logic stall, input logic [1:0] pid,
		input logic zl, input logic tog);
		logic [2:0] chk;
		logic [2:0] r;
		chk = (zl && tog) ? RSP_ACK : RSP_STALL;
		r = RSP_IGNORE;
		unique case (pid)
			PID_SETUP: begin
				unique case (mode)
					M_NAK_INOUT, M_STATUS_OUT, M_STALL_INOUT, M_IGNORE_INOUT, M_STATUS_IN,
					M_NAK_OUT_STIN, M_ACK_OUT_STIN, M_NAK_IN_STOUT, M_ACK_IN_STOUT: r = RSP_ACK;
					default: r = RSP_IGNORE;
				endcase
			end
			PID_IN: begin
				unique case (mode)
					M_NAK_INOUT, M_NAK_IN, M_NAK_IN_STOUT: r = RSP_NAK;
					M_STATUS_OUT, M_STALL_INOUT: r = RSP_STALL;
					M_STATUS_IN, M_NAK_OUT_STIN, M_ACK_OUT_STIN: r = RSP_TX0;
					M_ISO_IN, M_ACK_IN_STOUT: r = RSP_TXCNT;
					M_ACK_IN: r = stall ? RSP_STALL : RSP_TXCNT;
					M_ACK_OUT: r = stall ? RSP_STALL : RSP_IGNORE;
					default: r = RSP_IGNORE;
				endcase
			end
			PID_OUT: begin
				unique case (mode)
					M_NAK_INOUT, M_NAK_OUT, M_NAK_OUT_STIN: r = RSP_NAK;
					M_STATUS_OUT, M_NAK_IN_STOUT, M_ACK_IN_STOUT: r = chk;
					M_STALL_INOUT, M_STATUS_IN: r = RSP_STALL;
					M_ISO_OUT: r = RSP_RXISO;
					M_ACK_OUT: r = stall ? RSP_STALL : RSP_ACK;
					M_ACK_OUT_STIN: r = RSP_ACK;
					M_ACK_IN: r = stall ? RSP_STALL : RSP_IGNORE;
					default: r = RSP_IGNORE;
				endcase
			end
			default: r = RSP_IGNORE;
		endcase
		return r;
	endfunction

	// Mode after an acknowledged transaction
	function automatic logic [3:0] after_ack(input logic [3:0] mode, input logic [1:0] pid);
		logic [3:0] m;
		m = mode;
		if (pid == PID_SETUP && mode != M_DISABLE) begin
			m = M_NAK_INOUT;
		end else begin
			unique case (mode)
				M_ACK_OUT: m = M_NAK_OUT;
				M_ACK_IN: m = M_NAK_IN;
				M_ACK_OUT_STIN: m = M_NAK_OUT_STIN;
				M_ACK_IN_STOUT: m = M_NAK_IN_STOUT;
				default: m = mode;
			endcase
		end
		return m;
	endfunction

	// ==========================================================
	// State
	logic [7:0] mode_q [NUM_EP];
	logic [7:0] cnt_q [NUM_EP];
	logic [NUM_EP-1:0] irq_q;
	logic mode_lock_q;
	logic cnt_lock_q;
	logic force_q;
	uem_tok_s tok_l_q;
	logic [2:0] raw_l_q;
	logic [2:0] rsp_l_q;
	uem_rsp_s rsp_q;
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;

	// ==========================================================
	// Token answer decode
	logic ep_ok;
	logic [7:0] q_mode;
	logic q_stall;
	logic [2:0] q_raw;
	logic [2:0] q_act;

	always_comb begin
		ep_ok = tok.ep < 3'(NUM_EP);
		q_mode = ep_ok ? mode_q[tok.ep] : REG_RESET;
		q_stall = (tok.ep != 3'h0) && q_mode[MODE_STALL_BIT];
		q_raw = ep_ok ? answer(q_mode[3:0], q_stall, tok.pid, tok.zero_len, tok.tog) : RSP_IGNORE;
		q_act = (tok.pid != PID_IN && !tok.crc_ok) ? RSP_IGNORE : q_raw;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tok_l_q <= '0;
			raw_l_q <= RSP_IGNORE;
			rsp_l_q <= RSP_IGNORE;
			rsp_q <= '0;
		end else begin
			rsp_q.valid <= tok.valid;
			if (tok.valid) begin
				tok_l_q <= tok;
				raw_l_q <= q_raw;
				rsp_l_q <= q_act;
				rsp_q.code <= q_act;
				rsp_q.count <= ep_ok ? cnt_q[tok.ep][5:0] : 6'h00;
				rsp_q.tog <= ep_ok ? cnt_q[tok.ep][CNT_TOG_BIT] : 1'b0;
			end
		end
	end

	// ==========================================================
	// Update point effects
	logic u_go;
	logic [2:0] u_ep;
	logic u_ack;
	logic u_data;
	logic u_irq;
	logic u_seen;

	always_comb begin
		u_go = upd.valid && (tok_l_q.ep < 3'(NUM_EP));
		u_ep = tok_l_q.ep;
		u_ack = (rsp_l_q == RSP_ACK) || ((rsp_l_q == RSP_TXCNT || rsp_l_q == RSP_TX0) && upd.hs_ack);
		u_data = tok_l_q.pid != PID_IN && (raw_l_q == RSP_ACK || raw_l_q == RSP_RXISO);
		u_seen = rsp_l_q != RSP_IGNORE;
		u_irq = u_seen || u_data;
	end

	// ==========================================================
	// APB access
	uem_dec_s dec;
	logic adr_ok;
	logic acc;
	logic wr_acc;
	logic rd_acc;

	always_comb begin
		dec = decode(paddr[9:2]);
		adr_ok = dec.hit && paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0;
		acc = psel && penable && pready_q;
		wr_acc = acc && pwrite && adr_ok;
		rd_acc = acc && !pwrite && adr_ok;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && !adr_ok;
			// Writes and refused reads return zero
			if (psel && !penable) begin
				if (pwrite || !adr_ok) begin
					prdata_q <= '0;
				end else if (dec.is_irq) begin
					prdata_q <= 32'(irq_q);
				end else if (dec.is_mode) begin
					prdata_q <= {24'h0, mode_q[dec.ep]};
				end else begin
					prdata_q <= {24'h0, cnt_q[dec.ep]};
				end
			end
		end
	end

	// ==========================================================
	// Mode registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_EP; i++) begin
				mode_q[i] <= REG_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_EP; i++) begin
				if (u_go && u_ep == 3'(i) && u_seen) begin
					// Engine update beats a CPU write in the same cycle
					mode_q[i][3:0] <= u_ack ? after_ack(mode_q[i][3:0], tok_l_q.pid) : mode_q[i][3:0];
					if (u_ack) begin
						mode_q[i][MODE_ACK_BIT] <= 1'b1;
					end
					if (i == 0 && tok_l_q.pid == PID_IN) begin
						mode_q[i][MODE_IN_BIT] <= 1'b1;
					end
					if (i == 0 && tok_l_q.pid == PID_OUT) begin
						mode_q[i][MODE_OUT_BIT] <= 1'b1;
					end
				end else if (wr_acc && dec.is_mode && dec.ep == 3'(i)) begin
					if (i != 0) begin
						mode_q[i] <= pwdata[7:0];
					end else if (!mode_lock_q) begin
						mode_q[i][6:0] <= pwdata[6:0];
					end
				end
			end
			// Setup flag: set at the setup point, held while forced, a CPU write to the endpoint zero mode register clears it
			if (setup_point || force_q) begin
				mode_q[0][MODE_SETUP_BIT] <= 1'b1;
			end else if (wr_acc && dec.is_mode && dec.ep == 3'h0) begin
				mode_q[0][MODE_SETUP_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			force_q <= 1'b0;
		end else if (setup_point) begin
			force_q <= 1'b1;
		end else if (ctrl_write_end) begin
			force_q <= 1'b0;
		end
	end

	// ==========================================================
	// Counter registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_EP; i++) begin
				cnt_q[i] <= REG_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_EP; i++) begin
				if (u_go && u_ep == 3'(i) && u_data) begin
					cnt_q[i][5:0] <= upd.rx_bytes + CRC_BYTES;
					cnt_q[i][CNT_DVAL_BIT] <= tok_l_q.crc_ok;
					cnt_q[i][CNT_TOG_BIT] <= tok_l_q.tog;
				end else if (wr_acc && !dec.is_mode && !dec.is_irq && dec.ep == 3'(i)) begin
					if (i != 0 || !cnt_lock_q) begin
						cnt_q[i] <= pwdata[7:0];
					end
				end
			end
		end
	end

	// ==========================================================
	// Endpoint zero write locks
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_lock_q <= 1'b0;
			cnt_lock_q <= 1'b0;
		end else begin
			if (u_go && u_ep == 3'h0 && u_seen) begin
				mode_lock_q <= 1'b1;
			end else if (rd_acc && dec.is_mode && dec.ep == 3'h0) begin
				mode_lock_q <= 1'b0;
			end
			if (u_go && u_ep == 3'h0 && u_data) begin
				cnt_lock_q <= 1'b1;
			end else if (rd_acc && !dec.is_mode && !dec.is_irq && dec.ep == 3'h0) begin
				cnt_lock_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Endpoint interrupt flags
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_q <= '0;
		end else begin
			for (int i = 0; i < NUM_EP; i++) begin
				if (u_go && u_ep == 3'(i) && u_irq) begin
					irq_q[i] <= 1'b1;
				end else if (wr_acc && dec.is_irq && pwdata[i]) begin
					irq_q[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Outputs
	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign rsp = rsp_q;
	assign ep_irq = irq_q;
	assign ep0_setup_flag = mode_q[0][MODE_SETUP_BIT];
endmodule
`default_nettype wire

// ==== tb/uem_assertions.sv ====
// Port checker for the endpoint mode and counter block.
// Assumes one clock domain; bound from the bench top file.
`default_nettype none
module uem_assertions
	import uem_pkg::*;
#(
	parameter int NUM_EP = 5
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire uem_tok_s tok,
	input wire uem_upd_s upd,
	input wire logic setup_point,
	input wire logic ctrl_write_end,
	input wire uem_rsp_s rsp,
	input wire logic [NUM_EP-1:0] ep_irq,
	input wire logic ep0_setup_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] ep_q;
	logic frc_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================
	// Helpers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ep_q <= 3'h0;
		end else if (tok.valid) begin
			ep_q <= tok.ep;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			frc_q <= 1'b0;
		end else if (setup_point) begin
			frc_q <= 1'b1;
		end else if (ctrl_write_end) begin
			frc_q <= 1'b0;
		end
	end
	// ==========================================
	// Properties
	property p_rdy;
		psel && !penable |=> pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("no pready after setup");
	property p_rdz;
		pready |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0);
	endproperty
	a_rdz: assert property (p_rdz) else $error("bad read data lanes");
	property p_rsp;
		tok.valid |=> rsp.valid ##1 !rsp.valid;
	endproperty
	a_rsp: assert property (p_rsp) else $error("answer not one cycle after token");
	property p_one;
		rsp.valid |-> $past(tok.valid);
	endproperty
	a_one: assert property (p_one) else $error("answer without token");
	property p_ephi;
		tok.valid && tok.ep >= NUM_EP |=> rsp.code == RSP_IGNORE;
	endproperty
	a_ephi: assert property (p_ephi) else $error("unknown endpoint answered");
	property p_setup;
		setup_point |=> ep0_setup_flag;
	endproperty
	a_setup: assert property (p_setup) else $error("setup flag not set");
	property p_hold;
		frc_q && !ctrl_write_end |=> ep0_setup_flag;
	endproperty
	a_hold: assert property (p_hold) else $error("setup flag dropped while forced");
	property p_irqset;
		upd.valid && rsp.code != RSP_IGNORE |=> ep_irq[ep_q];
	endproperty
	a_irqset: assert property (p_irqset) else $error("irq not set at update");
	property p_irqhold;
		|($past(ep_irq) & ~ep_irq) |-> $past(psel) && $past(penable) && $past(pwrite);
	endproperty
	a_irqhold: assert property (p_irqhold) else $error("irq dropped without write");
endmodule
`default_nettype wire

// ==== tb/uem_host_model.sv ====
// Host controller model: issues tokens and update points.
// Assumes send() is called right after a rising edge.
`default_nettype none
module uem_host_model
	import uem_pkg::*;
(
	input wire logic clk_sys,
	output uem_tok_s tok,
	output uem_upd_s upd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		tok = '0;
		upd = '0;
	end
	// ==========================================
	// Token, then update after gap cycles
	task automatic send(input logic [2:0] ep, input logic [1:0] pid, input logic [3:0] f, input logic [5:0] nb,
		input int gap);
		tok <= {1'b1, ep, pid, f[2:0]};
		@(posedge clk_sys);
		tok <= {1'b0, ~tok[7:0]};
		repeat (gap) @(posedge clk_sys);
		upd <= {1'b1, f[3], nb};
		@(posedge clk_sys);
		upd <= {1'b0, ~upd[6:0]};
	endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the endpoint mode and counter block.
// Assumes APB tasks on the register side and the host model on the engine side.
`default_nettype none
module testbench;
	import uem_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] IN_T = 64'h4242550045003320;
	localparam logic [63:0] OUT_T = 64'h7700121203603720;
	localparam logic [15:0] SU_T = 16'hcc5e;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic setup_point = 1'b0;
	logic ctrl_write_end = 1'b0;
	logic pready, pslverr, ep0_setup_flag;
	logic [31:0] prdata;
	logic [4:0] ep_irq;
	logic [7:0] cnt;
	uem_tok_s tok;
	uem_upd_s upd;
	uem_rsp_s rsp;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed = 5089;
	logic [8:0] rdq[$];
	logic [9:0] rsq[$];
	logic [7:0] regs [10] = '{IDX_CNT0, IDX_MODE0, IDX_CNT1, IDX_MODE1, IDX_CNT2, IDX_MODE2, IDX_CNT3,
		IDX_MODE3, IDX_CNT4, IDX_MODE4};
	uem_endpoint_regs #(.NUM_EP(5)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.tok(tok), .upd(upd), .setup_point(setup_point), .ctrl_write_end(ctrl_write_end), .rsp(rsp),
		.ep_irq(ep_irq), .ep0_setup_flag(ep0_setup_flag));
	uem_host_model host (.clk_sys(clk_sys), .tok(tok), .upd(upd));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// ==========================================
	// Compare and report
	task automatic fail(input logic [9:0] g, input logic [9:0] e);
		miscompares++;
		$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
	endtask
	task automatic cmp_rd(input logic [8:0] g);
		logic [8:0] e;
		e = rdq.pop_front();
		checks_done++;
		if (g !== e) fail({1'b0, g}, {1'b0, e});
	endtask
	task automatic cmp_rsp(input logic [9:0] g);
		logic [9:0] e;
		e = rsq.pop_front();
		checks_done++;
		if (g !== e) fail(g, e);
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		if (pready === 1'b1 && !pwrite) cmp_rd({pslverr, prdata[7:0]});
		if (rsp.valid === 1'b1) cmp_rsp({rsp.code, rsp.tog, rsp.count});
		cycles++;
		if (cycles > 6000) begin
			miscompares++;
			stop_test();
		end
	end
	// ==========================================
	// Drivers
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'($random(seed)), d};
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [8:0] e);
		rdq.push_back(e);
		apb(1'b0, idx, 8'h00);
	endtask
	function automatic logic [2:0] ans(input logic [3:0] m, input logic [1:0] p, input logic st, input logic zt);
		logic [3:0] c;
		c = p == PID_IN ? IN_T[m*4 +: 4] : OUT_T[m*4 +: 4];
		if (p == PID_SETUP) return SU_T[m] ? RSP_ACK : RSP_IGNORE;
		if (st && (m == M_ACK_OUT || m == M_ACK_IN)) return RSP_STALL;
		if (c == 4'h7) return zt ? RSP_ACK : RSP_STALL;
		return c[2:0];
	endfunction
	task automatic txn(input logic [3:0] m, input logic st, input logic [1:0] p);
		logic [31:0] r;
		logic [2:0] c, ce;
		logic [5:0] nb;
		logic tg, zl, crc, hs, ack, upc;
		r = $random(seed);
		nb = r[0] ? 6'h00 : 6'(r[13:8] % 33);
		zl = nb == 6'h00;
		tg = r[1];
		hs = r[2];
		crc = p == PID_IN || OUT_T[m*4 +: 4] == 4'h7 || r[4:3] != 2'h0;
		c = ans(m, p, st, zl && tg);
		ce = crc ? c : RSP_IGNORE;
		upc = p != PID_IN && (c == RSP_ACK || c == RSP_RXISO);
		ack = ce == RSP_ACK || hs && (ce == RSP_TXCNT || ce == RSP_TX0);
		apb(1'b1, IDX_MODE1, {st, 3'h0, m});
		rsq.push_back({ce, cnt[7], cnt[5:0]});
		host.send(3'h1, p, {hs, crc, zl, tg}, nb, 1 + r[6:5]);
		if (upc) cnt = {tg, crc, nb + CRC_BYTES};
		rd(IDX_MODE1, {1'b0, st, 2'h0, ack, p == PID_SETUP && ack ? M_NAK_INOUT : ack && m[3] && m[0] ? m - 4'h1 : m});
		rd(IDX_CNT1, {1'b0, cnt});
		rd(IDX_IRQ, {7'h0, ce != RSP_IGNORE || upc, 1'b0});
		apb(1'b1, IDX_IRQ, 8'h02);
	endtask
	// ==========================================
	// Scenarios
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		foreach (regs[i]) rd(regs[i], 9'h000);
		rd(8'h30, 9'h100);
		rsq.push_back({RSP_IGNORE, 7'h00});
		host.send(3'h7, PID_OUT, 4'h4, 6'h03, 2);
		apb(1'b1, IDX_CNT1, 8'ha0);
		cnt = 8'ha0;
		for (int s = 0; s < 2; s++) begin
			for (int m = 0; m < 16; m++) begin
				for (int p = 1; p < 4; p++) begin
					if (s == 0 || m == 9 || m == 13) txn(4'(m), s[0], 2'(p));
				end
			end
		end
		apb(1'b1, IDX_MODE1, 8'h09);
		rsq.push_back({RSP_ACK, cnt[7], cnt[5:0]});
		host.send(3'h1, PID_OUT, 4'h4, 6'h05, 1);
		apb(1'b1, IDX_CNT1, 8'h85);
		rd(IDX_CNT1, 9'h085);
		apb(1'b1, IDX_MODE0, 8'h01);
		setup_point <= 1'b1;
		@(posedge clk_sys);
		setup_point <= 1'b0;
		rsq.push_back({RSP_ACK, 7'h00});
		host.send(3'h0, PID_SETUP, 4'h4, 6'h08, 3);
		apb(1'b1, IDX_MODE0, 8'h03);
		apb(1'b1, IDX_CNT0, 8'h3f);
		rd(IDX_MODE0, 9'h091);
		rd(IDX_CNT0, 9'h04a);
		apb(1'b1, IDX_CNT0, 8'h05);
		rd(IDX_CNT0, 9'h005);
		ctrl_write_end <= 1'b1;
		@(posedge clk_sys);
		ctrl_write_end <= 1'b0;
		apb(1'b1, IDX_MODE0, 8'h02);
		rd(IDX_MODE0, 9'h002);
		rsq.push_back({RSP_STALL, 7'h05});
		host.send(3'h0, PID_IN, 4'h4, 6'h00, 1);
		rsq.push_back({RSP_ACK, 7'h05});
		host.send(3'h0, PID_OUT, 4'h7, 6'h00, 2);
		rd(IDX_MODE0, 9'h072);
		rd(IDX_CNT0, 9'h0c2);
		stop_test();
	end
endmodule
bind uem_endpoint_regs uem_assertions #(.NUM_EP(NUM_EP)) chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr), .tok(tok),
	.upd(upd), .setup_point(setup_point), .ctrl_write_end(ctrl_write_end), .rsp(rsp), .ep_irq(ep_irq),
	.ep0_setup_flag(ep0_setup_flag));
`default_nettype wire
